// ==== bench/fdh_dma_ctrl_model.sv ====
/*
  Behavioural DMA controller for the FIFO DMA handshake block.
  Assumes requests ordered {tx B, tx A, rx B, rx A} and a bench that
  ends each burst by clearing i_en.
*/
`timescale 1ns/100ps
module fdh_dma_ctrl_model (
  input wire logic i_clk,
  input wire logic [3:0] i_req,
  input wire logic [3:0] i_en,
  input wire logic i_slow,
  output logic o_ack_a_n,
  output logic o_ack_b_n,
  output logic o_rd_n,
  output logic o_wr_n,
  output logic o_done,
  output logic [7:0] o_cnt
);
  int sel;
  int gap;
  logic drop;
  ////////////////////////////////////////
  // One burst per enable; strobes run until the request is seen to drop
  initial begin
    o_ack_a_n = 1'b1;
    o_ack_b_n = 1'b1;
    o_rd_n = 1'b1;
    o_wr_n = 1'b1;
    o_done = 1'b0;
    o_cnt = 8'h00;
    forever begin
      @(posedge i_clk);
      #1;
      sel = -1;
      for (int k = 3; k >= 0; k--) begin
        if (i_req[k] && i_en[k]) begin
          sel = k;
        end
      end
      if (sel >= 0) begin
        gap = i_slow ? 7 : 3;
        o_cnt = 8'h00;
        drop = 1'b0;
        // Acknowledge only once the bus is ours, well before any strobe
        o_ack_a_n = sel[0];
        o_ack_b_n = !sel[0];
        repeat (gap) @(posedge i_clk);
        #1;
        // Cap the burst so a stuck request cannot hang the run
        while (!drop && o_cnt < 8'h64) begin
          o_rd_n = sel > 1;
          o_wr_n = sel < 2;
          repeat (4) @(posedge i_clk);
          #1;
          o_rd_n = 1'b1;
          o_wr_n = 1'b1;
          o_cnt = o_cnt + 8'h01;
          repeat (4 + gap) begin
            @(posedge i_clk);
            #1;
            drop = drop | !i_req[sel];
          end
        end
        o_ack_a_n = 1'b1;
        o_ack_b_n = 1'b1;
        o_done = 1'b1;
        while (i_en != 4'h0) begin
          @(posedge i_clk);
          #1;
        end
        o_done = 1'b0;
      end
    end
  end
endmodule // fdh_dma_ctrl_model

// ==== bench/tb_top.sv ====
/*
  Self-checking bench for the FIFO DMA handshake block.
  Assumes the DMA controller model beside it and a 10 MHz clock.
*/
`timescale 1ns/100ps
module tb_top;
  logic clk, rst_n, ack_a_n, ack_b_n, rd_n, wr_n, done, slow, r0, r1, mz, m1, s2, ready, ce;
  logic mz_out, mz_oe, m1_out, m1_oe, rxb_req, txb_req, valid, frdy, wake, ign, pz, p1;
  logic [3:0] need, en, acc, req;
  logic [7:0] addr, rdata, cnt, dout, used;
  logic [11:0] code;
  logic [15:0] cnt_a, cnt_b;
  logic [1:0] start, role, er;
  logic [2:0] slot;
  int n_errors = 0;
  int n_checks = 0;
  int sizes[5] = '{64, 32, 16, 8, 4};
  ////////////////////////////////////////
  // Pin levels: the design wins a multi pin while it drives it
  assign pz = mz_oe ? mz_out : mz;
  assign p1 = m1_oe ? m1_out : m1;
  assign req = {txb_req, mz_oe & mz_out, rxb_req, m1_oe & m1_out};
  fdh_dma_handshake fdh_dma_handshake_inst (
    .i_clk_sys(clk), .i_reset_n(rst_n), .i_clk_en(ce), .i_dma_ack_a_n(ack_a_n),
    .i_dma_ack_b_n(ack_b_n), .i_rd_n(rd_n), .i_wr_n(wr_n), .i_addr_in(addr), .i_role_sel_0(r0),
    .i_role_sel_1(r1), .i_multi_pin_zero(pz), .i_multi_pin_one(p1), .i_slot_sel_2(s2),
    .i_rx_need(need), .i_rx_blk_code(code), .i_tx_count_a(cnt_a), .i_tx_count_b(cnt_b),
    .i_tx_start(start), .i_fifo_rdata(rdata), .o_fifo_rdata_ready(frdy), .o_tx_dma_req_b(txb_req),
    .o_rx_dma_req_b(rxb_req), .o_multi_pin_zero_out(mz_out), .o_multi_pin_zero_oe(mz_oe),
    .o_multi_pin_one_out(m1_out), .o_multi_pin_one_oe(m1_oe), .o_data_out(dout), .o_data_valid(valid),
    .i_data_ready(ready), .o_fifo_access(acc), .o_addr_ignored(ign), .o_addr_used(used),
    .o_role(role), .o_slot_sel(slot), .o_ext_wake(wake));
  fdh_dma_ctrl_model fdh_dma_ctrl_model_inst (
    .i_clk(clk), .i_req(req), .i_en(en), .i_slow(slow), .o_ack_a_n(ack_a_n), .o_ack_b_n(ack_b_n),
    .o_rd_n(rd_n), .o_wr_n(wr_n), .o_done(done), .o_cnt(cnt));
  ////////////////////////////////////////
  // Clock, and a fresh FIFO byte after every receive access
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    if (|acc[1:0]) begin
      #1;
      rdata = rdata + 8'h01;
    end
  end
  ////////////////////////////////////////
  // Shared helpers
  task automatic chk(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("MISMATCH t=%0t %s", $time, msg);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // One burst; the FIFO core side clears its need on the last access
  task automatic episode(input logic [3:0] e, input int idx, input int exp);
    int i;
    int g;
    i = 0;
    g = 0;
    en = e;
    while (done !== 1'b1 && g < 3000) begin
      tick(1);
      g++;
      if (acc[idx] === 1'b1) i++;
      if (idx < 2 && i == exp) need[idx] = 1'b0;
    end
    chk(cnt === 8'(exp), "burst length");
    chk(i == exp, "access pulse count");
    en = 4'h0;
    tick(3);
  endtask
  ////////////////////////////////////////
  // Scenarios
  task automatic t_roles();
    logic seen;
    for (int k = 0; k < 4; k++) begin
      r0 = k[1];
      r1 = k[0];
      tick(10);
      er = k < 2 ? fdh_pkg::FDH_ROLE_SUBSCRIBER_SIDE : fdh_pkg::FDH_ROLE_LINE_SUBSCRIBER;
      if (k == 3) er = fdh_pkg::FDH_ROLE_LINE_TRUNK;
      chk(role === er, "role decode");
      chk(mz_oe === (k < 2) && m1_oe === (k < 2), "multi pin direction");
      for (int s = 0; s < 8 && k > 1; s++) begin
        {s2, m1, mz} = 3'(s);
        tick(10);
        chk(slot === 3'(s), "slot select");
      end
    end
    r0 = 1'b0;
    r1 = 1'b1;
    tick(10);
    r1 = 1'b0;
    seen = 1'b0;
    repeat (10) begin
      tick(1);
      if (wake === 1'b1) seen = 1'b1;
    end
    chk(seen, "wake pulse");
    tick(1);
    r1 = 1'b1;
    tick(10);
    $display("test roles done");
  endtask
  task automatic t_freeze();
    ce = 1'b0;
    r0 = 1'b1;
    tick(10);
    chk(role === fdh_pkg::FDH_ROLE_SUBSCRIBER_SIDE, "role frozen while disabled");
    ce = 1'b1;
    tick(10);
    chk(role === fdh_pkg::FDH_ROLE_LINE_TRUNK, "role follows pins when enabled");
    r0 = 1'b0;
    tick(10);
    $display("test freeze done");
  endtask
  task automatic t_rx_b();
    for (int c = 0; c < 5; c++) begin
      code[5:3] = 3'(c);
      need[1] = 1'b1;
      tick(2);
      chk(rxb_req === 1'b1, "rx B request raised");
      episode(4'h2, 1, sizes[c]);
      chk(rxb_req === 1'b0, "rx B request dropped");
    end
    $display("test rx B done");
  endtask
  task automatic t_tx_a();
    cnt_a = 16'h0045;
    start = 2'h1;
    tick(1);
    start = 2'h0;
    tick(3);
    chk(mz_out === 1'b1 && mz_oe === 1'b1, "tx A request on pin");
    episode(4'h4, 2, 64);
    tick(2);
    episode(4'h4, 2, 5);
    chk(mz_out === 1'b0, "tx A count reached");
    $display("test tx A done");
  endtask
  task automatic t_indep();
    code[2:0] = 3'h3;
    need[0] = 1'b1;
    cnt_b = 16'h0003;
    start = 2'h2;
    tick(1);
    start = 2'h0;
    tick(3);
    chk(txb_req === 1'b1 && m1_out === 1'b1, "both requests up");
    episode(4'h8, 3, 3);
    chk(txb_req === 1'b0 && m1_out === 1'b1, "rx A request undisturbed");
    episode(4'h1, 0, 8);
    $display("test independence done");
  endtask
  task automatic t_buf();
    logic [7:0] base;
    ready = 1'b0;
    slow = 1'b1;
    code[2:0] = 3'h4;
    tick(10);
    chk(used === 8'h3c && ign === 1'b0, "address used when idle");
    base = rdata;
    need[0] = 1'b1;
    fork
      episode(4'h1, 0, 4);
      begin
        wait (ack_a_n === 1'b0);
        tick(6);
        chk(ign === 1'b1 && used === 8'h00, "address ignored under ack");
      end
    join
    chk(frdy === 1'b0 && valid === 1'b1, "buffer full");
    ready = 1'b1;
    for (int i = 0; i < 2; i++) begin
      chk(valid === 1'b1 && dout === base + 8'(i), "drained byte");
      tick(1);
    end
    chk(valid === 1'b0 && frdy === 1'b1, "buffer empty");
    $display("test buffer done");
  endtask
  ////////////////////////////////////////
  // Main sequence and watchdog
  initial begin
    {rst_n, slow, r0, mz, m1, s2} = 6'h00;
    {r1, ready, ce} = 3'h7;
    {need, en} = 8'h00;
    {cnt_a, cnt_b, code, start} = 46'h0;
    addr = 8'h3c;
    rdata = 8'h10;
    tick(3);
    rst_n = 1'b1;
    tick(5);
    t_roles();
    t_freeze();
    t_rx_b();
    t_tx_a();
    t_indep();
    t_buf();
    final_report();
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    final_report();
  end
endmodule // tb_top

// ==== hw/fdh_dma_handshake.sv ====
/*
  FIFO DMA handshake: request/acknowledge logic for the transmit and receive
  FIFOs of channels A and B, plus role-pin decoding and the shared multi pins.
  Assumes the FIFO core reports how many bytes each FIFO needs moved, that
  strobes and acknowledges are asynchronous pins, and that the DMA controller
  only acknowledges after winning the bus.
*/
// Summary of operation
// - Channel B receive request stays high while its receive FIFO needs emptying.
// - Each receive request moves a whole 64, 32, 16, 8 or 4 byte block.
// - Receive request drops right after the falling read strobe ending the block.
// - Transmit moves 64-byte blocks then one remainder block until count reached.
// - Channel A transmit request stays high while its FIFO needs loading.
// - Transmit request drops right after the falling write strobe ending transfer.
// - Low acknowledge means the DMA controller started the transfer cycles.
// - Acknowledge with read or write strobe selects the FIFO top byte.
// - While any acknowledge is active, address inputs are ignored.
// - Channel A requests appear on the multi pins only in subscriber-side mode.
// - Role pin zero low selects subscriber-side mode, high a line mode.
// - With role pin zero high, role pin one low is line-subscriber, high line-trunk.
// - In line modes the multi pins plus a third pin form a slot selector.
// - In subscriber-side mode role pin one is a wake input, falling edges detected.
`timescale 1ns/100ps

module fdh_dma_handshake #(
  parameter int CNT_W = fdh_pkg::CNT_W
) (
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic i_clk_en,
  // Pins from the DMA controller / host bus
  input wire logic i_dma_ack_a_n,
  input wire logic i_dma_ack_b_n,
  input wire logic i_rd_n,
  input wire logic i_wr_n,
  input wire logic [7:0] i_addr_in,
  input wire logic i_role_sel_0,
  input wire logic i_role_sel_1,
  input wire logic i_multi_pin_zero,
  input wire logic i_multi_pin_one,
  input wire logic i_slot_sel_2,
  // From the FIFO core (same clock)
  input wire logic [3:0] i_rx_need,
  input wire logic [11:0] i_rx_blk_code,
  input wire logic [CNT_W-1:0] i_tx_count_a,
  input wire logic [CNT_W-1:0] i_tx_count_b,
  input wire logic [1:0] i_tx_start,
  input wire logic [7:0] i_fifo_rdata,
  output logic o_fifo_rdata_ready,
  // Pins to the DMA controller
  output logic o_tx_dma_req_b,
  output logic o_rx_dma_req_b,
  output logic o_multi_pin_zero_out,
  output logic o_multi_pin_zero_oe,
  output logic o_multi_pin_one_out,
  output logic o_multi_pin_one_oe,
  output logic [7:0] o_data_out,
  output logic o_data_valid,
  input wire logic i_data_ready,
  // To the FIFO core
  output logic [3:0] o_fifo_access,
  output logic o_addr_ignored,
  output logic [7:0] o_addr_used,
  output logic [1:0] o_role,
  output logic [2:0] o_slot_sel,
  output logic o_ext_wake
);

  // Index: 0 rx A, 1 rx B, 2 tx A, 3 tx B
  localparam int NDIR = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: three stages, a change counts when stages two and three agree

  logic [2:0] s_ack_a_r, s_ack_b_r, s_rd_r, s_wr_r, s_rs0_r, s_rs1_r, s_mp0_r, s_mp1_r, s_ss2_r;
  logic ack_a_n_r, ack_b_n_r, rd_n_r, wr_n_r, rs0_r, rs1_r, mp0_r, mp1_r, ss2_r;

  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      s_ack_a_r <= fdh_pkg::SYNC_RST_HI;
      s_ack_b_r <= fdh_pkg::SYNC_RST_HI;
      s_rd_r <= fdh_pkg::SYNC_RST_HI;
      s_wr_r <= fdh_pkg::SYNC_RST_HI;
      s_rs0_r <= fdh_pkg::SYNC_RST;
      s_rs1_r <= fdh_pkg::SYNC_RST;
      s_mp0_r <= fdh_pkg::SYNC_RST;
      s_mp1_r <= fdh_pkg::SYNC_RST;
      s_ss2_r <= fdh_pkg::SYNC_RST;
    end else if (i_clk_en) begin
      s_ack_a_r <= {s_ack_a_r[1:0], i_dma_ack_a_n};
      s_ack_b_r <= {s_ack_b_r[1:0], i_dma_ack_b_n};
      s_rd_r <= {s_rd_r[1:0], i_rd_n};
      s_wr_r <= {s_wr_r[1:0], i_wr_n};
      s_rs0_r <= {s_rs0_r[1:0], i_role_sel_0};
      s_rs1_r <= {s_rs1_r[1:0], i_role_sel_1};
      s_mp0_r <= {s_mp0_r[1:0], i_multi_pin_zero};
      s_mp1_r <= {s_mp1_r[1:0], i_multi_pin_one};
      s_ss2_r <= {s_ss2_r[1:0], i_slot_sel_2};
    end
  end

  // Filtered levels: only update when stages two and three agree
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      ack_a_n_r <= 1'b1;
      ack_b_n_r <= 1'b1;
      rd_n_r <= 1'b1;
      wr_n_r <= 1'b1;
      rs0_r <= 1'b0;
      rs1_r <= 1'b0;
      mp0_r <= 1'b0;
      mp1_r <= 1'b0;
      ss2_r <= 1'b0;
    end else if (i_clk_en) begin
      if (s_ack_a_r[1] == s_ack_a_r[2]) ack_a_n_r <= s_ack_a_r[2];
      if (s_ack_b_r[1] == s_ack_b_r[2]) ack_b_n_r <= s_ack_b_r[2];
      if (s_rd_r[1] == s_rd_r[2]) rd_n_r <= s_rd_r[2];
      if (s_wr_r[1] == s_wr_r[2]) wr_n_r <= s_wr_r[2];
      if (s_rs0_r[1] == s_rs0_r[2]) rs0_r <= s_rs0_r[2];
      if (s_rs1_r[1] == s_rs1_r[2]) rs1_r <= s_rs1_r[2];
      if (s_mp0_r[1] == s_mp0_r[2]) mp0_r <= s_mp0_r[2];
      if (s_mp1_r[1] == s_mp1_r[2]) mp1_r <= s_mp1_r[2];
      if (s_ss2_r[1] == s_ss2_r[2]) ss2_r <= s_ss2_r[2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Role decoding

  logic [1:0] role_r;
  logic subscriber_side_mode;

  // Role follows the filtered pins while the clock enable is high
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      role_r <= fdh_pkg::FDH_ROLE_SUBSCRIBER_SIDE;
    end else if (i_clk_en) begin
      if (!rs0_r) begin
        role_r <= fdh_pkg::FDH_ROLE_SUBSCRIBER_SIDE;
      end else if (!rs1_r) begin
        role_r <= fdh_pkg::FDH_ROLE_LINE_SUBSCRIBER;
      end else begin
        role_r <= fdh_pkg::FDH_ROLE_LINE_TRUNK;
      end
    end
  end

  assign subscriber_side_mode = (role_r == fdh_pkg::FDH_ROLE_SUBSCRIBER_SIDE);
  assign o_role = role_r;

  // Slot selector and wake detection
  logic [2:0] slot_r;
  logic rs1_d_r, wake_r;

  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      slot_r <= 3'h0;
      rs1_d_r <= 1'b0; // Same level as the filtered pin after reset, so no false edge
      wake_r <= 1'b0;
    end else if (i_clk_en) begin
      rs1_d_r <= rs1_r;
      if (!subscriber_side_mode) begin
        slot_r <= {ss2_r, mp1_r, mp0_r};
      end
      // Filtered mode pin, not role_r: pin one dropping as pin zero rises is no wake
      wake_r <= !rs0_r && rs1_d_r && !rs1_r;
    end
  end

  assign o_slot_sel = slot_r;
  assign o_ext_wake = wake_r;

  ////////////////////////////////////////////////////////////////////////////
  // Strobe decode: acknowledge acts as chip select

  logic rd_d_r, wr_d_r;
  logic rd_fall, wr_fall;
  logic [NDIR-1:0] access;

  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      rd_d_r <= 1'b1;
      wr_d_r <= 1'b1;
    end else if (i_clk_en) begin
      rd_d_r <= rd_n_r;
      wr_d_r <= wr_n_r;
    end
  end

  assign rd_fall = rd_d_r && !rd_n_r;
  assign wr_fall = wr_d_r && !wr_n_r;

  // Access pulses per direction; a falling strobe under acknowledge counts as one access
  assign access[0] = !ack_a_n_r && rd_fall;
  assign access[1] = !ack_b_n_r && rd_fall;
  assign access[2] = !ack_a_n_r && wr_fall;
  assign access[3] = !ack_b_n_r && wr_fall;
  assign o_fifo_access = access & {NDIR{i_clk_en}};

  // Address inputs are masked while any acknowledge is active
  assign o_addr_ignored = !ack_a_n_r || !ack_b_n_r;
  assign o_addr_used = o_addr_ignored ? 8'h00 : i_addr_in;

  ////////////////////////////////////////////////////////////////////////////
  // Per-direction request engines, independent of each other

  logic [NDIR-1:0] req_r;
  logic [fdh_pkg::BLK_W-1:0] blk_left_r [NDIR];
  logic [CNT_W-1:0] tx_left_r [2];

  // Receive engines: a request covers one whole block, dropped on its last read
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_rx
      always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
          req_r[g] <= 1'b0;
          blk_left_r[g] <= '0;
        end else if (i_clk_en) begin
          if (!req_r[g] && i_rx_need[g]) begin
            req_r[g] <= 1'b1;
            blk_left_r[g] <= fdh_pkg::rx_block_bytes(i_rx_blk_code[3*g +: 3]);
          end else if (req_r[g] && access[g]) begin
            blk_left_r[g] <= blk_left_r[g] - 7'h01;
            if (blk_left_r[g] == 7'h01) req_r[g] <= 1'b0;
          end
        end
      end
    end

    // Transmit engines: 64-byte blocks then the remainder, until the count ends
    for (g = 0; g < 2; g++) begin : g_tx
      always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
          req_r[2+g] <= 1'b0;
          blk_left_r[2+g] <= '0;
          tx_left_r[g] <= '0;
        end else if (i_clk_en) begin
          if (i_tx_start[g] && !req_r[2+g]) begin
            tx_left_r[g] <= (g == 0) ? i_tx_count_a : i_tx_count_b;
          end else if (!req_r[2+g] && tx_left_r[g] != '0) begin
            req_r[2+g] <= 1'b1;
            if (tx_left_r[g] >= CNT_W'(fdh_pkg::TX_BLOCK_BYTES)) begin
              blk_left_r[2+g] <= 7'(fdh_pkg::TX_BLOCK_BYTES);
            end else begin
              blk_left_r[2+g] <= tx_left_r[g][6:0];
            end
          end else if (req_r[2+g] && access[2+g]) begin
            blk_left_r[2+g] <= blk_left_r[2+g] - 7'h01;
            tx_left_r[g] <= tx_left_r[g] - CNT_W'(1'b1);
            if (blk_left_r[2+g] == 7'h01) req_r[2+g] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // Channel A requests only drive the multi pins in subscriber-side mode
  assign o_multi_pin_zero_out = req_r[2] && subscriber_side_mode;
  assign o_multi_pin_zero_oe = subscriber_side_mode;
  assign o_multi_pin_one_out = req_r[0] && subscriber_side_mode;
  assign o_multi_pin_one_oe = subscriber_side_mode;
  assign o_rx_dma_req_b = req_r[1];
  assign o_tx_dma_req_b = req_r[3];

  ////////////////////////////////////////////////////////////////////////////
  // Two-entry read-data buffer: a receive access while both entries are full stores no FIFO byte

  logic [7:0] buf_r [2];
  logic [1:0] cnt_r;
  logic wp_r, rp_r;
  logic push, pop;

  assign o_fifo_rdata_ready = (cnt_r != 2'h2);
  assign push = (access[0] || access[1]) && o_fifo_rdata_ready && i_clk_en;
  assign pop = o_data_valid && i_data_ready && i_clk_en;
  assign o_data_valid = (cnt_r != 2'h0);
  assign o_data_out = buf_r[rp_r];

  // Buffer pointers and storage
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      cnt_r <= 2'h0;
      wp_r <= 1'b0;
      rp_r <= 1'b0;
      buf_r[0] <= 8'h00;
      buf_r[1] <= 8'h00;
    end else begin
      if (push) begin
        buf_r[wp_r] <= i_fifo_rdata;
        wp_r <= ~wp_r;
      end
      if (pop) rp_r <= ~rp_r;
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  // Last access of a block, as the request engines see it
  sequence s_rxb_last;
    i_clk_en && req_r[1] && access[1] && blk_left_r[1] == 7'h01;
  endsequence

  sequence s_txa_last;
    i_clk_en && req_r[2] && access[2] && blk_left_r[2] == 7'h01;
  endsequence

  AST_RXB_DROP: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    s_rxb_last |=> !o_rx_dma_req_b)
    else $error("receive request B not dropped after last read");

  AST_TXA_DROP: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    s_txa_last |=> !req_r[2])
    else $error("transmit request A not dropped after last write");

  AST_RXB_ARM: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (i_clk_en && !req_r[1] && i_rx_need[1]) |=> o_rx_dma_req_b && blk_left_r[1] != 7'h00)
    else $error("receive request B not raised for a waiting FIFO");

  AST_TXA_BLK: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    $rose(req_r[2]) |-> blk_left_r[2] == 7'(fdh_pkg::TX_BLOCK_BYTES) || tx_left_r[0] == CNT_W'(blk_left_r[2]))
    else $error("transmit block A neither full nor the remainder");

  AST_TXBLK_MAX: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    $rose(req_r[3]) |-> blk_left_r[3] <= 7'h40 && blk_left_r[3] != 7'h00)
    else $error("transmit block size out of range");

  AST_MP_LINE: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (i_clk_en && rs0_r) |=> !o_multi_pin_zero_oe && !o_multi_pin_one_oe && !o_multi_pin_zero_out)
    else $error("multi pins driven in a line mode");

  AST_ROLE: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (i_clk_en && !rs0_r) |=> role_r == fdh_pkg::FDH_ROLE_SUBSCRIBER_SIDE)
    else $error("role not subscriber-side with role pin zero low");

  AST_ROLE_LINE: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (i_clk_en && rs0_r && rs1_r) |=> role_r == fdh_pkg::FDH_ROLE_LINE_TRUNK)
    else $error("line-trunk role not selected");

  AST_ADDR: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (!ack_a_n_r || !ack_b_n_r) |-> o_addr_used == 8'h00)
    else $error("address used while acknowledge active");

  AST_WAKE: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    o_ext_wake |-> !$past(rs0_r) && !$past(rs1_r) && $past(rs1_d_r))
    else $error("wake pulse without falling edge");

  AST_RXREQ_HOLD: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (req_r[1] && !access[1]) |=> req_r[1])
    else $error("receive request B dropped mid-block");

endmodule // fdh_dma_handshake

// ==== hw/fdh_pkg.sv ====
/*
  Package for the FIFO DMA handshake block: timing, block sizes, role
  encodings and pin-synchroniser reset values.
  Assumes a single 10 MHz system clock and a synchronous active-low reset.
*/
package fdh_pkg;

  // System clock period in ns
  localparam int CLK_PERIOD_NS = 100;

  // Transmit DMA block size in bytes
  localparam int TX_BLOCK_BYTES = 64;

  // Receive block size codes: 64, 32, 16, 8 or 4 bytes
  typedef enum logic [2:0] {
    FDH_RXB_64 = 3'h0,
    FDH_RXB_32 = 3'h1,
    FDH_RXB_16 = 3'h2,
    FDH_RXB_8  = 3'h3,
    FDH_RXB_4  = 3'h4
  } fdh_rxblk_e;

  // Role selected by the two role pins
  typedef enum logic [1:0] {
    FDH_ROLE_SUBSCRIBER_SIDE = 2'h0,
    FDH_ROLE_LINE_SUBSCRIBER = 2'h1,
    FDH_ROLE_LINE_TRUNK      = 2'h2
  } fdh_role_e;

  // Per-direction handshake states
  typedef enum logic [1:0] {
    FDH_ST_IDLE = 2'h0,
    FDH_ST_REQ  = 2'h1,
    FDH_ST_XFER = 2'h2
  } fdh_state_e;

  // Width of byte counters
  localparam int CNT_W = 16;
  localparam int BLK_W = 7;

  // Reset value of the three-stage pin synchronisers
  localparam logic [2:0] SYNC_RST = 3'h0;
  localparam logic [2:0] SYNC_RST_HI = 3'h7;

  // Receive block size in bytes for a code
  function automatic logic [6:0] rx_block_bytes(input logic [2:0] code);
    case (code)
      3'h0: rx_block_bytes = 7'h40;
      3'h1: rx_block_bytes = 7'h20;
      3'h2: rx_block_bytes = 7'h10;
      3'h3: rx_block_bytes = 7'h08;
      default: rx_block_bytes = 7'h04;
    endcase
  endfunction

endpackage
